/* static_memory_bus_cycles.sv */
// Function
// RULE_01: Inputs sampled on rising clock edge.
// RULE_02: Read and write strobes launch on falling edge.
// RULE_03: Bank zero strobes optionally on top address bits.
// RULE_04: Far side holds acknowledge stable around rising edge.
// RULE_05: Wait cycles only when wait setting two or more.
// RULE_06: Byte enables follow port width.
// RULE_07: Thirteen clocks DMA switch before DMA transfer.
// RULE_08: One idle period after strobe-controlled transfers.
// RULE_09: Chip-select burst read: four then two clocks.
// RULE_10: Chip-select burst write: four then two clocks.
// RULE_11: Read-strobe burst read: three then two clocks.
// RULE_12: Write-strobe burst write: three then two clocks.
// RULE_13: Zero wait burst read: two then one.
`timescale 1ns/1ps
`default_nettype none

module static_memory_bus_cycles (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Transfer requests
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqBurst,
    input wire logic reqDma,
    input wire logic [static_mem_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [static_mem_pkg::DATA_W-1:0] reqData,
    output logic reqReady,
    // Transfer results
    output logic [static_mem_pkg::DATA_W-1:0] rdData,
    output logic rdValid,
    output logic wordDone,
    output logic xferDone,
    output logic xferError,
    output logic busy,
    output logic insertedWaitCycle,
    // Configuration
    input wire static_mem_pkg::strobe_mode_t strobeMode,
    input wire logic [static_mem_pkg::WAIT_W-1:0] waitStates,
    input wire logic [1:0] burstCycleSetting,
    input wire static_mem_pkg::port_width_t portWidth,
    input wire logic bank0Strobes,
    // Memory pins
    output logic [static_mem_pkg::ADDR_W-1:0] memAddr,
    output logic csN,
    output logic [static_mem_pkg::BE_W-1:0] byteEnableN,
    output logic rwN,
    output logic [static_mem_pkg::DATA_W-1:0] dataOut,
    output logic dataOe,
    input wire logic [static_mem_pkg::DATA_W-1:0] dataIn,
    input wire logic transferAckN,
    input wire logic transferErrorN,
    output logic oeN,
    output logic weN
);
    import static_mem_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    bus_state_t state;
    bus_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [BEAT_W-1:0] beat;
    logic [ADDR_W-1:0] curAddr;
    strobe_mode_t curMode;
    logic [WAIT_W-1:0] curWait;
    logic [1:0] curBcyc;
    logic curWrite;
    logic curBurst;
    logic ownerDma;
    logic firstWord;
    logic readActive;
    logic writeActive;
    logic [1:0] addrTop;
    logic [ADDR_W-1:0] addrRise;

    logic accept;
    logic wordEnd;
    logic errorEnd;
    logic lastBeat;
    logic finish;

    // ************************************************************
    // Sequencing
    // ************************************************************
    // The acknowledge and error pins are used only through these rising-edge decisions.
    assign accept = reqValid && reqReady; // RULE_01
    assign errorEnd = (state == ST_ACCESS) && !transferErrorN;
    // Early termination is taken from the acknowledge sampled at the
    // rising edge; the far side owns its setup and hold.
    assign wordEnd = (state == ST_ACCESS)
        && ((cnt == CNT_ZERO) || !transferAckN); // RULE_04
    assign lastBeat = !curBurst || (beat == BURST_LAST_BEAT);
    assign finish = errorEnd || (wordEnd && lastBeat);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE: begin
                if (accept && reqDma && !ownerDma) begin
                    next_state = ST_DMA_SWITCH;
                    next_cnt = DMA_SWITCH_CLOCKS - ONE_CLOCK; // RULE_07
                end else if (accept) begin
                    next_state = ST_ACCESS;
                    // Wait cycles count only from the minimum upward.
                    next_cnt = firstWordLoad(strobeMode, waitStates); // RULE_05
                end
            end
            ST_DMA_SWITCH: begin
                if (cnt == CNT_ZERO) begin
                    next_state = ST_ACCESS;
                    next_cnt = firstWordLoad(curMode, curWait); // RULE_05
                end else begin
                    next_cnt = cnt - ONE_CLOCK;
                end
            end
            ST_ACCESS: begin
                if (finish) begin
                    // Strobe-controlled modes need a bus rest period.
                    if (curMode != MODE_CS) begin
                        next_state = ST_NULL; // RULE_08
                    end else begin
                        next_state = ST_IDLE;
                    end
                end else if (wordEnd) begin
                    // RULE_09 RULE_10 RULE_11 RULE_12 RULE_13
                    next_cnt = burstWordLoad(curBcyc);
                end else begin
                    next_cnt = cnt - ONE_CLOCK;
                end
            end
            ST_NULL: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cnt <= CNT_ZERO;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            reqReady <= 1'b0;
            busy <= 1'b0;
        end else begin
            reqReady <= (next_state == ST_IDLE);
            busy <= (next_state != ST_IDLE);
        end
    end

    // ************************************************************
    // Transfer context
    // ************************************************************
    // Mode, wait, burst cycle and direction settings are frozen at acceptance so a
    // change mid-burst cannot reshape a cycle; portWidth and bank0Strobes stay live.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            curMode <= MODE_CS;
            curWait <= '0;
            curBcyc <= 2'h0;
            curWrite <= 1'b0;
            curBurst <= 1'b0;
        end else if (accept) begin
            curMode <= strobeMode;
            curWait <= waitStates;
            curBcyc <= burstCycleSetting;
            curWrite <= reqWrite;
            curBurst <= reqBurst;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ownerDma <= 1'b0;
        end else if (accept) begin
            ownerDma <= reqDma; // RULE_07
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            beat <= '0;
            firstWord <= 1'b0;
            curAddr <= '0;
        end else if (accept) begin
            beat <= '0;
            firstWord <= 1'b1;
            curAddr <= reqAddr;
        end else if (wordEnd && !finish) begin
            beat <= beat + BEAT_ONE;
            firstWord <= 1'b0;
            curAddr <= curAddr + WORD_STEP;
        end
    end

    // ************************************************************
    // Rising-edge pins
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            addrRise <= '0;
            csN <= 1'b1;
            byteEnableN <= BE_NONE_N;
            rwN <= 1'b1;
        end else begin
            addrRise <= (next_state == ST_ACCESS && wordEnd)
                ? curAddr + WORD_STEP
                : (accept ? reqAddr : curAddr); // RULE_02
            csN <= (next_state != ST_ACCESS); // RULE_02
            byteEnableN <= (next_state == ST_ACCESS)
                ? byteEnables(portWidth) : BE_NONE_N; // RULE_06
            rwN <= !((next_state == ST_ACCESS)
                && (accept ? reqWrite : curWrite));
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dataOut <= '0;
            dataOe <= 1'b0;
        end else begin
            // The next burst word is taken from reqData at each word end.
            if (accept || (wordEnd && !finish)) begin
                dataOut <= reqData; // RULE_02
            end
            dataOe <= (next_state == ST_ACCESS)
                && (accept ? reqWrite : curWrite);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            readActive <= 1'b0;
            writeActive <= 1'b0;
        end else begin
            readActive <= (next_state == ST_ACCESS)
                && !(accept ? reqWrite : curWrite);
            writeActive <= (next_state == ST_ACCESS)
                && (accept ? reqWrite : curWrite);
        end
    end

    // Without bank zero strobes every address bit is a rising-edge flop,
    // so the top bits never lag half a clock behind the rest.
    assign memAddr = bank0Strobes
        ? {addrTop, addrRise[ADDR_LOW_TOP:0]}
        : addrRise; // RULE_03

    strobe_launch launch (
        .mclk(mclk),
        .nrst(nrst),
        .readActive(readActive),
        .writeActive(writeActive),
        .bank0Strobes(bank0Strobes),
        .addrHigh(curAddr[BANK0_READ_BIT:BANK0_WRITE_BIT]),
        .oeN(oeN),
        .weN(weN),
        .addrTop(addrTop)
    );

    // ************************************************************
    // Wait cycle indicator
    // ************************************************************
    // Marks clocks of the first word beyond the mode's base length.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            insertedWaitCycle <= 1'b0;
        end else begin
            insertedWaitCycle <= (state == ST_ACCESS) && firstWord
                && (curWait >= WAIT_INSERT_MIN) && !wordEnd
                && (cnt > firstWordLoad(curMode, curWait)
                    - {1'b0, curWait}); // RULE_05
        end
    end

    // ************************************************************
    // Results
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdData <= '0;
            rdValid <= 1'b0;
        end else begin
            rdValid <= wordEnd && !errorEnd && !curWrite;
            if (wordEnd && !errorEnd && !curWrite) begin
                rdData <= dataIn; // RULE_01
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wordDone <= 1'b0;
            xferDone <= 1'b0;
            xferError <= 1'b0;
        end else begin
            wordDone <= wordEnd && !errorEnd;
            xferDone <= finish;
            xferError <= errorEnd;
        end
    end

endmodule : static_memory_bus_cycles

`default_nettype wire

/* static_mem_pkg.sv */
package static_mem_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 28;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int CNT_W = 5;
    localparam int WAIT_W = 4;
    localparam int BEAT_W = 2;

    // ************************************************************
    // Modes and states
    // ************************************************************
    typedef enum logic [1:0] {MODE_CS, MODE_OE, MODE_WE} strobe_mode_t;
    typedef enum logic [1:0] {PORT_8, PORT_16, PORT_32} port_width_t;
    typedef enum logic [1:0] {
        ST_IDLE, ST_DMA_SWITCH, ST_ACCESS, ST_NULL
    } bus_state_t;

    // ************************************************************
    // Timing constants
    // ************************************************************
    localparam logic [WAIT_W-1:0] WAIT_INSERT_MIN = 4'h2;
    localparam logic [CNT_W-1:0] CS_FIRST_BASE = 5'h2;
    localparam logic [CNT_W-1:0] STROBE_FIRST_BASE = 5'h1;
    localparam logic [CNT_W-1:0] DMA_SWITCH_CLOCKS = 5'hd;
    localparam logic [CNT_W-1:0] ONE_CLOCK = 5'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h0;
    localparam logic [BEAT_W-1:0] BURST_LAST_BEAT = 2'h3;
    localparam logic [BEAT_W-1:0] BEAT_ONE = 2'h1;
    localparam logic [ADDR_W-1:0] WORD_STEP = 28'h4;

    // ************************************************************
    // Pin encodings
    // ************************************************************
    localparam logic [BE_W-1:0] BE_MSB_ONLY_N = 4'h7;
    localparam logic [BE_W-1:0] BE_ALL_N = 4'h0;
    localparam logic [BE_W-1:0] BE_NONE_N = 4'hf;
    localparam int BANK0_READ_BIT = 27;
    localparam int BANK0_WRITE_BIT = 26;
    localparam int ADDR_LOW_TOP = 25;

    // Counter load for the first word: base plus any inserted waits, less one.
    function automatic logic [CNT_W-1:0] firstWordLoad(
        input strobe_mode_t m,
        input logic [WAIT_W-1:0] w
    );
        logic [CNT_W-1:0] waits;
        logic [CNT_W-1:0] base;
        waits = (w >= WAIT_INSERT_MIN) ? {1'b0, w} : CNT_ZERO;
        base = (m == MODE_CS) ? CS_FIRST_BASE : STROBE_FIRST_BASE;
        return base + waits - ONE_CLOCK;
    endfunction : firstWordLoad

    // Later burst words take the burst cycle setting plus one clock.
    function automatic logic [CNT_W-1:0] burstWordLoad(
        input logic [1:0] burst_cycle_setting
    );
        return {3'h0, burst_cycle_setting};
    endfunction : burstWordLoad

    function automatic logic [BE_W-1:0] byteEnables(
        input port_width_t pw
    );
        return (pw == PORT_8) ? BE_MSB_ONLY_N : BE_ALL_N;
    endfunction : byteEnables

endpackage : static_mem_pkg

/* strobe_launch.sv */
`timescale 1ns/1ps
`default_nettype none

module strobe_launch (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Strobe requests from the rising-edge logic
    input wire logic readActive,
    input wire logic writeActive,
    input wire logic bank0Strobes,
    input wire logic [1:0] addrHigh,
    // Falling-edge outputs
    output logic oeN,
    output logic weN,
    output logic [1:0] addrTop
);
    import static_mem_pkg::*;

    // ************************************************************
    // Falling-edge launch
    // ************************************************************
    // Half a clock after the rising edge the address is stable, so the
    // strobes never open on a moving address.
    always_ff @(negedge mclk) begin
        if (!nrst) begin
            oeN <= 1'b1;
            weN <= 1'b1;
        end else begin
            oeN <= !readActive; // RULE_02
            weN <= !writeActive; // RULE_02
        end
    end

    always_ff @(negedge mclk) begin
        if (!nrst) begin
            addrTop <= 2'h3;
        end else if (bank0Strobes) begin
            addrTop <= {!readActive, !writeActive}; // RULE_03
        end else begin
            addrTop <= addrHigh;
        end
    end

endmodule : strobe_launch

`default_nettype wire

/* static_memory_bus_cycles_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module static_memory_bus_cycles_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Requests and configuration
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic reqBurst,
    input wire logic reqDma,
    input wire static_mem_pkg::strobe_mode_t strobeMode,
    input wire logic [static_mem_pkg::WAIT_W-1:0] waitStates,
    input wire logic [1:0] burstCycleSetting,
    input wire static_mem_pkg::port_width_t portWidth,
    input wire logic bank0Strobes,
    // Results and pins
    input wire logic wordDone,
    input wire logic xferDone,
    input wire logic [static_mem_pkg::ADDR_W-1:0] memAddr,
    input wire logic csN,
    input wire logic [static_mem_pkg::BE_W-1:0] byteEnableN,
    input wire logic oeN,
    input wire logic weN
);
    import static_mem_pkg::*;

    // ****************
    // Helper logic
    // ****************
    logic oeRise;
    logic csFall;
    logic ownDma;
    logic weRise;
    logic [27:0] addrFall;
    wire logic acc = reqValid && reqReady;
    wire logic w2 = waitStates == 4'h2 && burstCycleSetting == 2'h1;

    always_ff @(posedge mclk) oeRise <= oeN;
    always_ff @(negedge mclk) csFall <= csN;
    always_ff @(posedge mclk) weRise <= weN;
    always_ff @(negedge mclk) addrFall <= memAddr;
    always_ff @(posedge mclk) begin
        if (!nrst) ownDma <= 1'b0;
        else if (acc) ownDma <= reqDma;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence beats2;
        wordDone ##2 wordDone ##2 wordDone ##2 wordDone;
    endsequence
    sequence beats1;
        wordDone ##1 wordDone ##1 wordDone ##1 wordDone;
    endsequence

    a_oe_on_fall: assert property (
        @(negedge mclk) disable iff (!nrst) oeN == oeRise)
        else $error("oeN moved at a rising edge");
    a_we_on_fall: assert property (
        @(negedge mclk) disable iff (!nrst) weN == weRise)
        else $error("weN moved at a rising edge");
    a_addr_on_rise: assert property (!bank0Strobes &&
        !$past(bank0Strobes) |-> memAddr == addrFall)
        else $error("address moved at a falling edge");
    a_cs_on_rise: assert property (csN == csFall)
        else $error("csN moved at a falling edge");
    a_be_width: assert property (!csN |-> byteEnableN ==
        (portWidth == PORT_8 ? BE_MSB_ONLY_N : BE_ALL_N))
        else $error("byte enables wrong for port width");
    a_null_gap: assert property (xferDone && strobeMode != MODE_CS
        |-> !reqReady ##1 reqReady) else $error("no null period");
    a_cs_ready_back: assert property (xferDone && strobeMode == MODE_CS
        |-> reqReady) else $error("ready late after transfer");
    a_cs_burst: assert property (acc && reqBurst && !reqDma && w2 &&
        strobeMode == MODE_CS |-> ##5 beats2)
        else $error("chip-select burst not 4-2-2-2");
    a_strobe_burst: assert property (acc && reqBurst && !reqDma && w2
        && strobeMode != MODE_CS |-> ##4 beats2)
        else $error("strobe burst not 3-2-2-2");
    a_fast_burst: assert property (acc && reqBurst && !reqDma &&
        strobeMode == MODE_CS && waitStates == 4'h0 &&
        burstCycleSetting == 2'h0 |-> ##3 beats1)
        else $error("zero wait burst not 2-1-1-1");
    a_low_wait: assert property (acc && !reqBurst && !reqDma &&
        strobeMode == MODE_CS && waitStates < 4'h2
        |=> !csN ##1 !csN ##1 csN) else $error("waits with low setting");
    a_dma_switch: assert property (acc && reqDma && !ownDma
        |-> ##13 csN ##1 !csN) else $error("DMA switch not 13 clocks");
    a_bank0_pins: assert property (bank0Strobes && $past(bank0Strobes)
        |-> memAddr[27] == oeN && memAddr[26] == weN)
        else $error("bank zero strobes not on top address bits");
endmodule : static_memory_bus_cycles_monitor

bind static_memory_bus_cycles static_memory_bus_cycles_monitor mon (
    .mclk, .nrst, .reqValid, .reqReady, .reqBurst, .reqDma, .strobeMode,
    .waitStates, .burstCycleSetting, .portWidth, .bank0Strobes, .wordDone,
    .xferDone, .memAddr, .csN, .byteEnableN, .oeN, .weN);

`default_nettype wire

/* sram_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module sram_partner (
    // Memory pins
    input wire logic mclk,
    // Test control
    input wire logic earlyAck,
    // Memory address and strobes
    input wire logic [27:0] memAddr,
    input wire logic csN,
    input wire logic rwN,
    output logic [31:0] dataIn,
    output logic transferAckN,
    output logic transferErrorN
);
    // Deselected, the bus shows a toggling pattern, never a stale word.
    logic [31:0] junk = 32'h5a5a5a5a;

    always_ff @(posedge mclk) junk <= ~junk;
    assign dataIn = (!csN && rwN) ? {6'h15, memAddr[25:0]} : junk;
    // With earlyAck set the memory acknowledges one clock into each word, ending it after two clocks; the
    // acknowledge only moves just after a rising edge, never near one.
    always_ff @(posedge mclk) begin
        transferAckN <= !(earlyAck && !csN && transferAckN);
    end
    assign transferErrorN = 1'b1;
endmodule : sram_partner

`default_nettype wire

/* static_memory_bus_cycles_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module static_memory_bus_cycles_tb_top;
    import static_mem_pkg::*;
    typedef struct {int gap; logic rd; logic [31:0] d;} note_t;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic reqValid = 1'b0, reqWrite = 1'b0, reqBurst = 1'b0, reqDma = 1'b0;
    logic [ADDR_W-1:0] reqAddr = 28'h0, memAddr;
    logic [DATA_W-1:0] reqData = 32'h0, rdData, dataOut, dataIn, lastOut;
    logic reqReady, rdValid, wordDone, xferDone, csN, rwN, dataOe, oeN, weN;
    logic transferAckN, transferErrorN;
    logic earlyAck = 1'b0, xferError, busy, insertedWaitCycle;
    logic [BE_W-1:0] byteEnableN;
    strobe_mode_t strobeMode = MODE_CS;
    port_width_t portWidth = PORT_32;
    logic [WAIT_W-1:0] waitStates = 4'h0;
    logic [1:0] burstCycleSetting = 2'h0;
    logic bank0Strobes = 1'b0;
    logic [31:0] lfsr = 32'h6041;
    int fail_count = 0, n_tests = 0, cyc = 0;
    time tPrev = 0;
    note_t notes[$];
    note_t nt;

    always #4 mclk = ~mclk;

    static_memory_bus_cycles dut (.mclk, .nrst, .reqValid, .reqWrite,
        .reqBurst, .reqDma, .reqAddr, .reqData, .reqReady, .rdData, .rdValid,
        .wordDone, .xferDone, .xferError, .busy, .insertedWaitCycle,
        .strobeMode, .waitStates, .burstCycleSetting, .portWidth,
        .bank0Strobes, .memAddr, .csN, .byteEnableN, .rwN, .dataOut, .dataOe,
        .dataIn, .transferAckN, .transferErrorN, .oeN, .weN);

    sram_partner mem (.mclk, .earlyAck, .memAddr, .csN, .rwN, .dataIn,
        .transferAckN, .transferErrorN);

    // ****************
    // Checking
    // ****************
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nextRand

    task automatic check(input string what, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    // Outputs are read mid-cycle, once the rising edge's updates have landed.
    always @(negedge mclk) begin
        if (!csN) check("byteEnableN", portWidth == PORT_8 ?
            BE_MSB_ONLY_N : BE_ALL_N, byteEnableN);
        if (!csN) check("rwN", {31'h0, !reqWrite}, {31'h0, rwN});
        if (wordDone && notes.size() > 0) begin
            nt = notes.pop_front();
            check("word clocks", nt.gap, 32'(($time - 4 - tPrev) / 8));
            tPrev = $time - 4;
            check("word data", nt.d, nt.rd ? rdData : lastOut);
            check("rdValid", {31'h0, nt.rd}, {31'h0, rdValid});
        end else if (wordDone) begin
            check("spare word", 32'h0, 32'h1);
        end
        if (dataOe) lastOut = dataOut;
    end

    // ****************
    // Stimulus
    // ****************
    task automatic xfer(input strobe_mode_t m, input logic wr, bu, dma,
        input logic [3:0] ws, input logic [1:0] bc, input port_width_t pw,
        input int g1, g2);
        logic [31:0] w[4];
        int j;
        int nw;
        nw = 0;
        for (int i = 0; i < 4; i++) begin
            lfsr = nextRand(lfsr);
            w[i] = lfsr;
        end
        @(negedge mclk);
        for (int t = 0; t < 60 && !reqReady; t++) @(negedge mclk);
        {strobeMode, reqWrite, reqBurst, reqDma} = {m, wr, bu, dma};
        {waitStates, burstCycleSetting, portWidth} = {ws, bc, pw};
        reqAddr = {lfsr[27:4], 4'h0};
        for (int i = 0; i < (bu ? 4 : 1); i++) notes.push_back('{i ? g2 : g1,
            !wr, wr ? w[i] : {6'h15, 26'(reqAddr[25:0] + 4 * i)}});
        reqData = w[0];
        reqValid = 1'b1;
        @(posedge mclk);
        tPrev = $time;
        @(negedge mclk);
        reqValid = 1'b0;
        check("busy", 32'h1, {31'h0, busy});
        reqData = w[1];
        j = 2;
        for (int t = 0; t < 80 && !xferDone; t++) begin
            @(negedge mclk);
            if (insertedWaitCycle) nw++;
            if (wordDone && j < 4) begin
                reqData = w[j];
                j++;
            end
        end
        check("xferDone", 32'h1, {31'h0, xferDone});
        check("xferError", 32'h0, {31'h0, xferError});
        if (!earlyAck) check("wait clocks", ws >= WAIT_INSERT_MIN ?
            {28'h0, ws} : 32'h0, 32'(nw));
    endtask : xfer

    initial begin
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        xfer(MODE_CS, 0, 0, 0, 4'h2, 2'h1, PORT_8, 4, 0);
        xfer(MODE_CS, 0, 0, 0, 4'h2, 2'h1, PORT_16, 4, 0);
        xfer(MODE_CS, 0, 1, 0, 4'h2, 2'h1, PORT_32, 4, 2);
        xfer(MODE_CS, 1, 1, 0, 4'h2, 2'h1, PORT_8, 4, 2);
        xfer(MODE_OE, 0, 1, 0, 4'h2, 2'h1, PORT_32, 3, 2);
        bank0Strobes = 1'b1;
        xfer(MODE_WE, 1, 1, 0, 4'h2, 2'h1, PORT_32, 3, 2);
        bank0Strobes = 1'b0;
        xfer(MODE_CS, 0, 1, 0, 4'h0, 2'h0, PORT_32, 2, 1);
        xfer(MODE_CS, 0, 0, 0, {3'h0, lfsr[0]}, 2'h0, PORT_32, 2, 0);
        xfer(MODE_CS, 0, 0, 1, 4'h0, 2'h0, PORT_32, 15, 0);
        xfer(MODE_CS, 1, 0, 1, 4'h0, 2'h0, PORT_32, 2, 0);
        earlyAck = 1'b1;
        xfer(MODE_CS, 0, 0, 0, 4'h2, 2'h1, PORT_32, 2, 0);
        earlyAck = 1'b0;
        repeat (4) @(negedge mclk);
        check("notes left", 32'h0, 32'(notes.size()));
        complete_run();
    end
endmodule : static_memory_bus_cycles_tb_top

`default_nettype wire
